/* File: rtl/pse_event_interrupt_unit.sv */
// event capture, alert summary, mask and alert pin for a four-port power controller
module pse_event_interrupt_unit (
    input wire logic clk_i,
    input wire logic resetn_i,
    // serial register port
    input wire logic scl_i,
    input wire logic sda_in_i,
    output logic sda_out_o,
    output logic sda_oe_o,
    input wire logic [3:0] addr_pins_i,
    input wire logic standalone_strap_i,
    // port state and event sources, same clock
    input wire logic [peiu_pkg::PORTS-1:0] port_power_ok_i,
    input wire logic [peiu_pkg::PORTS-1:0] port_switch_on_i,
    input wire logic [peiu_pkg::PORTS-1:0] discovery_done_i,
    input wire logic [peiu_pkg::PORTS-1:0] class_done_i,
    input wire logic [peiu_pkg::PORTS-1:0] unplug_fault_i,
    input wire logic [peiu_pkg::PORTS-1:0] overload_timeout_i,
    input wire logic [peiu_pkg::PORTS-1:0] limit_timeout_i,
    input wire logic [peiu_pkg::PORTS-1:0] launch_fail_i,
    input wire logic thermal_trip_i,
    input wire logic bad_switch_i,
    input wire logic core_supply_low_i,
    input wire logic neg_supply_low_i,
    // open-drain active-low alert pin
    output logic alert_n_o,
    output logic alert_oe_o
);
    import peiu_pkg::*;

    logic reg_wr, reg_rd;
    logic [DW-1:0] reg_addr, reg_wdata, reg_rdata;
    logic [DW-1:0] power_ev, detect_ev, fault_ev, startup_ev, supply_ev;
    logic [DW-1:0] mask_q, mask_d;
    logic [PORTS-1:0] pok_prev_q, son_prev_q;
    logic primed_q;
    logic strap_s1_q, strap_s2_q;
    logic [1:0] settle_q;
    logic mask_written_q;
    logic global_en_q;
    logic alert_pull_q;

    function automatic logic hit(input logic [DW-1:0] a, input logic [DW-1:0] b);
        return a == b;
    endfunction : hit

    peiu_serial_slave u_slave (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .scl_i(scl_i),
        .sda_in_i(sda_in_i),
        .addr_pins_i(addr_pins_i),
        .sda_out_o(sda_out_o),
        .sda_oe_o(sda_oe_o),
        .reg_wr_o(reg_wr),
        .reg_rd_o(reg_rd),
        .reg_addr_o(reg_addr),
        .reg_wdata_o(reg_wdata),
        .reg_rdata_i(reg_rdata)
    );

    // write decode
    wire logic wr_mask = reg_wr & hit(reg_addr, ADDR_MASK);
    wire logic wr_global = reg_wr & hit(reg_addr, ADDR_GLOBAL_EN);
    wire logic clear_all = reg_wr & hit(reg_addr, ADDR_CLEAR_CMD) & reg_wdata[CLEAR_ALL_BIT];

    // clearing reads act only through the odd address of each pair
    wire logic clr_power = reg_rd & hit(reg_addr, ADDR_POWER_CLR);
    wire logic clr_detect = reg_rd & hit(reg_addr, ADDR_DETECT_CLR);
    wire logic clr_fault = reg_rd & hit(reg_addr, ADDR_FAULT_CLR);
    wire logic clr_startup = reg_rd & hit(reg_addr, ADDR_STARTUP_CLR);
    wire logic clr_supply = reg_rd & hit(reg_addr, ADDR_SUPPLY_CLR);

    // edges of the port status bits; first cycle after reset only primes history
    wire logic [PORTS-1:0] pok_edge = (port_power_ok_i ^ pok_prev_q) & {PORTS{primed_q}};
    wire logic [PORTS-1:0] son_edge = (port_switch_on_i ^ son_prev_q) & {PORTS{primed_q}};

    wire logic [DW-1:0] power_set = {pok_edge, son_edge};
    wire logic [DW-1:0] detect_set = {class_done_i, discovery_done_i};
    wire logic [DW-1:0] fault_set = {unplug_fault_i, overload_timeout_i};
    wire logic [DW-1:0] startup_set = {limit_timeout_i, launch_fail_i};
    wire logic [DW-1:0] supply_set = {thermal_trip_i, bad_switch_i, core_supply_low_i,
                                      neg_supply_low_i, 4'h0};

    peiu_event_bank #(.WIDTH(DW), .RESET_VAL(RST_EVENT)) u_power (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .set_i(power_set),
        .clr_read_i(clr_power),
        .clr_all_i(clear_all),
        .flags_o(power_ev)
    );

    peiu_event_bank #(.WIDTH(DW), .RESET_VAL(RST_EVENT)) u_detect (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .set_i(detect_set),
        .clr_read_i(clr_detect),
        .clr_all_i(clear_all),
        .flags_o(detect_ev)
    );

    peiu_event_bank #(.WIDTH(DW), .RESET_VAL(RST_EVENT)) u_fault (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .set_i(fault_set),
        .clr_read_i(clr_fault),
        .clr_all_i(clear_all),
        .flags_o(fault_ev)
    );

    peiu_event_bank #(.WIDTH(DW), .RESET_VAL(RST_EVENT)) u_startup (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .set_i(startup_set),
        .clr_read_i(clr_startup),
        .clr_all_i(clear_all),
        .flags_o(startup_ev)
    );

    peiu_event_bank #(.WIDTH(DW), .RESET_VAL(RST_SUPPLY)) u_supply (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .set_i(supply_set),
        .clr_read_i(clr_supply),
        .clr_all_i(clear_all),
        .flags_o(supply_ev)
    );

    // summary is pure logic over the event registers, so it tracks every clear
    wire logic [DW-1:0] summary;
    assign summary[SUM_SUPPLY] = |(supply_ev & SUPPLY_ACTIVE);
    assign summary[SUM_STARTUP] = |startup_ev[3:0];
    assign summary[SUM_OVERLOAD] = |{fault_ev[3:0], startup_ev[7:4]};
    assign summary[SUM_CLASS] = |detect_ev[7:4];
    assign summary[SUM_DISCOVERY] = |detect_ev[3:0];
    assign summary[SUM_UNPLUG] = |fault_ev[7:4];
    assign summary[SUM_POWER_OK] = |power_ev[7:4];
    assign summary[SUM_SWITCH_ON] = |power_ev[3:0];

    // thermal, core-low and negative-low supply alerts bypass the mask
    wire logic forced = |(supply_ev & SUPPLY_UNMASKABLE);
    wire logic alert_want = (|(summary & mask_q)) | forced;

    // read mux; unmapped offsets read zero
    assign reg_rdata =
        hit(reg_addr, ADDR_SUMMARY) ? summary :
        hit(reg_addr, ADDR_MASK) ? mask_q :
        (hit(reg_addr, ADDR_POWER_VIEW) || hit(reg_addr, ADDR_POWER_CLR)) ? power_ev :
        (hit(reg_addr, ADDR_DETECT_VIEW) || hit(reg_addr, ADDR_DETECT_CLR)) ? detect_ev :
        (hit(reg_addr, ADDR_FAULT_VIEW) || hit(reg_addr, ADDR_FAULT_CLR)) ? fault_ev :
        (hit(reg_addr, ADDR_STARTUP_VIEW) || hit(reg_addr, ADDR_STARTUP_CLR)) ? startup_ev :
        (hit(reg_addr, ADDR_SUPPLY_VIEW) || hit(reg_addr, ADDR_SUPPLY_CLR)) ? supply_ev :
        hit(reg_addr, ADDR_GLOBAL_EN) ? {global_en_q, 7'h00} :
        8'h00;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pok_prev_q <= '0;
            son_prev_q <= '0;
            primed_q <= 1'b0;
        end else begin
            pok_prev_q <= port_power_ok_i;
            son_prev_q <= port_switch_on_i;
            primed_q <= 1'b1;
        end
    end

    // strap is caught by the third clock after release, once its synchroniser has settled
    wire logic strap_ready = settle_q == STRAP_SETTLE;
    wire logic strap_load = (settle_q == STRAP_SETTLE - 2'h1) & ~mask_written_q;
    assign mask_d = wr_mask ? reg_wdata :
                    strap_load ? (strap_s2_q ? RST_MASK_STANDALONE : RST_MASK_HOSTED) :
                    mask_q;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            strap_s1_q <= 1'b0;
            strap_s2_q <= 1'b0;
            settle_q <= 2'h0;
            mask_written_q <= 1'b0;
            mask_q <= RST_MASK_HOSTED;
        end else begin
            strap_s1_q <= standalone_strap_i;
            strap_s2_q <= strap_s1_q;
            settle_q <= strap_ready ? settle_q : settle_q + 2'h1;
            mask_written_q <= mask_written_q | wr_mask;
            mask_q <= mask_d;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            global_en_q <= RST_GLOBAL_EN;
        end else if (wr_global) begin
            global_en_q <= reg_wdata[GLOBAL_EN_BIT];
        end
    end

    // a disabled pin is released entirely rather than driven high
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            alert_pull_q <= 1'b0;
        end else begin
            alert_pull_q <= alert_want & global_en_q;
        end
    end

    assign alert_oe_o = alert_pull_q;
    assign alert_n_o = ~alert_pull_q;
endmodule : pse_event_interrupt_unit

/* File: rtl/peiu_pkg.sv */
// shared constants for the power-sourcing event and alert unit
package peiu_pkg;
    localparam int PORTS = 4;
    localparam int DW = 8;
    // register offsets
    localparam logic [7:0] ADDR_SUMMARY = 8'h00;
    localparam logic [7:0] ADDR_MASK = 8'h01;
    localparam logic [7:0] ADDR_POWER_VIEW = 8'h02;
    localparam logic [7:0] ADDR_POWER_CLR = 8'h03;
    localparam logic [7:0] ADDR_DETECT_VIEW = 8'h04;
    localparam logic [7:0] ADDR_DETECT_CLR = 8'h05;
    localparam logic [7:0] ADDR_FAULT_VIEW = 8'h06;
    localparam logic [7:0] ADDR_FAULT_CLR = 8'h07;
    localparam logic [7:0] ADDR_STARTUP_VIEW = 8'h08;
    localparam logic [7:0] ADDR_STARTUP_CLR = 8'h09;
    localparam logic [7:0] ADDR_SUPPLY_VIEW = 8'h0a;
    localparam logic [7:0] ADDR_SUPPLY_CLR = 8'h0b;
    localparam logic [7:0] ADDR_GLOBAL_EN = 8'h17;
    localparam logic [7:0] ADDR_CLEAR_CMD = 8'h1a;
    // field positions
    localparam int GLOBAL_EN_BIT = 7;
    localparam int CLEAR_ALL_BIT = 7;
    localparam int SUM_SUPPLY = 7;
    localparam int SUM_STARTUP = 6;
    localparam int SUM_OVERLOAD = 5;
    localparam int SUM_CLASS = 4;
    localparam int SUM_DISCOVERY = 3;
    localparam int SUM_UNPLUG = 2;
    localparam int SUM_POWER_OK = 1;
    localparam int SUM_SWITCH_ON = 0;
    // supply bits that bypass the mask: thermal, core low, negative low
    localparam logic [7:0] SUPPLY_UNMASKABLE = 8'hb0;
    localparam logic [7:0] SUPPLY_ACTIVE = 8'hf0;
    // reset values
    localparam logic [7:0] RST_EVENT = 8'h00;
    localparam logic [7:0] RST_SUPPLY = 8'h02;
    localparam logic [7:0] RST_MASK_STANDALONE = 8'he4;
    localparam logic [7:0] RST_MASK_HOSTED = 8'h80;
    localparam logic RST_GLOBAL_EN = 1'b1;
    // cycles after reset release before the synchronised strap is valid
    localparam logic [1:0] STRAP_SETTLE = 2'h3;
    // serial port: upper device address bits, arbitrary value
    localparam logic [2:0] DEV_ADDR_HI = 3'h2;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    typedef enum logic [6:0] {
        PEIU_IDLE = 7'b000_0001,
        PEIU_ADDR = 7'b000_0010,
        PEIU_PTR = 7'b000_0100,
        PEIU_WDATA = 7'b000_1000,
        PEIU_ACK = 7'b001_0000,
        PEIU_RDATA = 7'b010_0000,
        PEIU_MACK = 7'b100_0000
    } peiu_state_t;
endpackage : peiu_pkg

/* File: rtl/peiu_event_bank.sv */
// one sticky event register with view, clear-on-read and clear-all
module peiu_event_bank #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [WIDTH-1:0] set_i,
    input wire logic clr_read_i,
    input wire logic clr_all_i,
    output logic [WIDTH-1:0] flags_o
);
    logic [WIDTH-1:0] flags_q;
    logic [WIDTH-1:0] flags_d;
    wire logic clr = clr_read_i | clr_all_i;

    // a new event in the clearing cycle survives the clear
    assign flags_d = (clr ? '0 : flags_q) | set_i;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            flags_q <= RESET_VAL;
        end else begin
            flags_q <= flags_d;
        end
    end

    assign flags_o = flags_q;
endmodule : peiu_event_bank

/* File: rtl/peiu_serial_slave.sv */
// serial register port slave: pointer byte, then data bytes with auto-increment
module peiu_serial_slave (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic scl_i,
    input wire logic sda_in_i,
    input wire logic [3:0] addr_pins_i,
    output logic sda_out_o,
    output logic sda_oe_o,
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [peiu_pkg::DW-1:0] reg_addr_o,
    output logic [peiu_pkg::DW-1:0] reg_wdata_o,
    input wire logic [peiu_pkg::DW-1:0] reg_rdata_i
);
    import peiu_pkg::*;

    logic scl_s1_q, scl_s2_q, scl_s3_q;
    logic sda_s1_q, sda_s2_q, sda_s3_q;
    logic [3:0] apin_s1_q, apin_s2_q;
    peiu_state_t state_q, after_q;
    logic [3:0] bitcnt_q;
    logic [7:0] shift_q, ptr_q;
    logic drive_q, wr_q, rd_q, nack_q;

    wire logic start = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
    wire logic stop = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;
    wire logic rise = scl_s2_q & ~scl_s3_q;
    wire logic fall = ~scl_s2_q & scl_s3_q;
    wire logic byte_done = bitcnt_q == BITS_PER_BYTE;
    wire logic addr_hit = shift_q[7:1] == {DEV_ADDR_HI, apin_s2_q};
    wire logic receiving = state_q inside {PEIU_ADDR, PEIU_PTR, PEIU_WDATA};

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            scl_s1_q <= 1'b1;
            scl_s2_q <= 1'b1;
            scl_s3_q <= 1'b1;
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
            sda_s3_q <= 1'b1;
            apin_s1_q <= 4'h0;
            apin_s2_q <= 4'h0;
        end else begin
            scl_s1_q <= scl_i;
            scl_s2_q <= scl_s1_q;
            scl_s3_q <= scl_s2_q;
            sda_s1_q <= sda_in_i;
            sda_s2_q <= sda_s1_q;
            sda_s3_q <= sda_s2_q;
            apin_s1_q <= addr_pins_i;
            apin_s2_q <= apin_s1_q;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= PEIU_IDLE;
            after_q <= PEIU_IDLE;
            bitcnt_q <= 4'h0;
            shift_q <= 8'h00;
            ptr_q <= 8'h00;
            drive_q <= 1'b0;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            nack_q <= 1'b0;
        end else begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            if (wr_q) begin
                ptr_q <= ptr_q + 8'h01;
            end
            if (rd_q) begin
                // byte fetched now, so a clearing read clears what was returned
                shift_q <= reg_rdata_i;
                drive_q <= ~reg_rdata_i[7];
                ptr_q <= ptr_q + 8'h01;
                bitcnt_q <= 4'h1;
            end
            if (stop) begin
                state_q <= PEIU_IDLE;
                drive_q <= 1'b0;
            end else if (start) begin
                state_q <= PEIU_ADDR;
                bitcnt_q <= 4'h0;
                drive_q <= 1'b0;
            end else if (rise && receiving) begin
                shift_q <= {shift_q[6:0], sda_s2_q};
                bitcnt_q <= bitcnt_q + 4'h1;
            end else if (rise && state_q == PEIU_MACK) begin
                nack_q <= sda_s2_q;
            end else if (fall) begin
                unique case (state_q)
                    PEIU_ADDR: begin
                        if (byte_done && addr_hit) begin
                            drive_q <= 1'b1;
                            after_q <= shift_q[0] ? PEIU_RDATA : PEIU_PTR;
                            state_q <= PEIU_ACK;
                        end else if (byte_done) begin
                            state_q <= PEIU_IDLE;
                        end
                    end
                    PEIU_PTR: begin
                        if (byte_done) begin
                            ptr_q <= shift_q;
                            drive_q <= 1'b1;
                            after_q <= PEIU_WDATA;
                            state_q <= PEIU_ACK;
                        end
                    end
                    PEIU_WDATA: begin
                        if (byte_done) begin
                            wr_q <= 1'b1;
                            drive_q <= 1'b1;
                            after_q <= PEIU_WDATA;
                            state_q <= PEIU_ACK;
                        end
                    end
                    PEIU_ACK: begin
                        drive_q <= 1'b0;
                        bitcnt_q <= 4'h0;
                        rd_q <= after_q == PEIU_RDATA;
                        state_q <= after_q;
                    end
                    PEIU_RDATA: begin
                        if (byte_done) begin
                            drive_q <= 1'b0;
                            state_q <= PEIU_MACK;
                        end else begin
                            drive_q <= ~shift_q[6];
                            shift_q <= {shift_q[6:0], 1'b0};
                            bitcnt_q <= bitcnt_q + 4'h1;
                        end
                    end
                    PEIU_MACK: begin
                        rd_q <= ~nack_q;
                        state_q <= nack_q ? PEIU_IDLE : PEIU_RDATA;
                    end
                    PEIU_IDLE: begin
                        drive_q <= 1'b0;
                    end
                    default: begin
                        state_q <= PEIU_IDLE;
                    end
                endcase
            end
        end
    end

    assign sda_oe_o = drive_q;
    assign sda_out_o = 1'b0;
    assign reg_wr_o = wr_q;
    assign reg_rd_o = rd_q;
    assign reg_addr_o = ptr_q;
    assign reg_wdata_o = shift_q;
endmodule : peiu_serial_slave

/* File: test/peiu_props.sv */
// alert pin and serial port checks of the event unit, bound to its top
module peiu_props (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic scl_i,
    input wire logic sda_oe_o,
    input wire logic alert_n_o,
    input wire logic alert_oe_o,
    input wire logic [peiu_pkg::PORTS-1:0] port_power_ok_i,
    input wire logic [peiu_pkg::PORTS-1:0] port_switch_on_i,
    input wire logic [peiu_pkg::PORTS-1:0] discovery_done_i,
    input wire logic [peiu_pkg::PORTS-1:0] class_done_i,
    input wire logic [peiu_pkg::PORTS-1:0] unplug_fault_i,
    input wire logic [peiu_pkg::PORTS-1:0] overload_timeout_i,
    input wire logic [peiu_pkg::PORTS-1:0] limit_timeout_i,
    input wire logic [peiu_pkg::PORTS-1:0] launch_fail_i,
    input wire logic thermal_trip_i,
    input wire logic bad_switch_i,
    input wire logic core_supply_low_i,
    input wire logic neg_supply_low_i
);
    import peiu_pkg::*;
    // cycles since the serial clock moved, and since any alert cause moved
    logic [3:0] bus_q;
    logic [3:0] any_q;
    wire ev_w = |{discovery_done_i, class_done_i, unplug_fault_i, overload_timeout_i,
        limit_timeout_i, launch_fail_i, thermal_trip_i, bad_switch_i, core_supply_low_i,
        neg_supply_low_i};
    wire sup_w = thermal_trip_i | core_supply_low_i | neg_supply_low_i;
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            bus_q <= 4'hf;
            any_q <= 4'hf;
        end else begin
            bus_q <= $changed(scl_i) ? 4'h0 : bus_q + {3'h0, bus_q != 4'hf};
            any_q <= (ev_w || $changed(port_power_ok_i) || $changed(port_switch_on_i)) ?
                4'h0 : any_q + {3'h0, any_q != 4'hf};
        end
    end
    sequence s_quiet2;
        !alert_oe_o [*2];
    endsequence
    sequence s_sup_rise;
        sup_w ##[1:3] alert_oe_o;
    endsequence
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);
    a_pin_polarity: assert property (alert_n_o == !alert_oe_o)
        else $error("alert pin level differs from its enable");
    a_reset_quiet: assert property ($rose(resetn_i) |-> s_quiet2)
        else $error("alert right after reset release");
    a_reset_alert: assert property (disable iff (1'b0) !resetn_i |-> !alert_oe_o)
        else $error("alert pulled during reset");
    a_reset_sda: assert property (disable iff (1'b0) !resetn_i |-> !sda_oe_o)
        else $error("data line pulled during reset");
    a_supply_unmasked: assert property (sup_w |-> ##[1:3] alert_oe_o)
        else $error("supply alert missed the pin");
    a_supply_hold: assert property (s_sup_rise |=> alert_oe_o [*3])
        else $error("supply alert dropped without a clear");
    a_fall_needs_bus: assert property ($fell(alert_oe_o) |-> bus_q < 4'hc)
        else $error("alert released with no serial access");
    a_rise_needs_cause: assert property ($rose(alert_oe_o) |->
        any_q < 4'h6 || bus_q < 4'hc) else $error("alert raised with no cause");
endmodule : peiu_props

bind pse_event_interrupt_unit peiu_props u_props (
    .clk_i(clk_i), .resetn_i(resetn_i), .scl_i(scl_i), .sda_oe_o(sda_oe_o),
    .alert_n_o(alert_n_o), .alert_oe_o(alert_oe_o), .port_power_ok_i(port_power_ok_i),
    .port_switch_on_i(port_switch_on_i), .discovery_done_i(discovery_done_i),
    .class_done_i(class_done_i), .unplug_fault_i(unplug_fault_i),
    .overload_timeout_i(overload_timeout_i), .limit_timeout_i(limit_timeout_i),
    .launch_fail_i(launch_fail_i), .thermal_trip_i(thermal_trip_i),
    .bad_switch_i(bad_switch_i), .core_supply_low_i(core_supply_low_i),
    .neg_supply_low_i(neg_supply_low_i));

/* File: test/peiu_host.sv */
// serial host model: drives the serial clock, pulls the data line, reads it back
module peiu_host #(
    parameter logic [3:0] PINS = 4'h5
) (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_pull_o
);
    timeunit 1ns;
    timeprecision 100ps;
    import peiu_pkg::*;
    localparam logic [7:0] DEV_W = {DEV_ADDR_HI, PINS, 1'b0};
    int nacks = 0;
    initial begin
        scl_o = 1'b1;
        sda_pull_o = 1'b0;
    end
    // six cycles a phase keeps clear of the synchroniser delay in the device
    task automatic drv(input logic c, input logic p);
        scl_o = c;
        sda_pull_o = p;
        repeat (6) @(posedge clk_i);
        #2;
    endtask : drv
    task automatic bitx(input logic b, output logic r);
        drv(1'b0, !b);
        drv(1'b1, !b);
        r = sda_i;
        drv(1'b0, !b);
    endtask : bitx
    // also a repeated start: data released first, then pulled while the clock is high
    task automatic st;
        drv(scl_o, 1'b0);
        drv(1'b1, 1'b0);
        drv(1'b1, 1'b1);
        drv(1'b0, 1'b1);
    endtask : st
    task automatic xb(input logic [7:0] d, input logic chk, output logic [7:0] r);
        logic a;
        for (int i = 7; i >= 0; i--) bitx(d[i], r[i]);
        bitx(1'b1, a);
        if (chk && a) nacks++;
    endtask : xb
    task automatic hd(input logic [7:0] p);
        logic [7:0] r;
        st();
        xb(DEV_W, 1'b1, r);
        xb(p, 1'b1, r);
    endtask : hd
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        logic [7:0] r;
        hd(p);
        xb(d, 1'b1, r);
        drv(1'b0, 1'b1);
        drv(1'b1, 1'b1);
        drv(1'b1, 1'b0);
    endtask : wr
    // single byte read, answered with no-acknowledge before the stop
    task automatic rd(input logic [7:0] p, output logic [7:0] d);
        logic [7:0] r;
        hd(p);
        st();
        xb(DEV_W | 8'h01, 1'b1, r);
        xb(8'hff, 1'b0, d);
        drv(1'b0, 1'b1);
        drv(1'b1, 1'b1);
        drv(1'b1, 1'b0);
    endtask : rd
    // two-byte read: master acknowledge after the first byte, so the pointer moves on
    task automatic rd2(input logic [7:0] p, output logic [7:0] d0, output logic [7:0] d1);
        logic [7:0] r;
        logic a;
        hd(p);
        st();
        xb(DEV_W | 8'h01, 1'b1, r);
        for (int i = 7; i >= 0; i--) bitx(1'b1, d0[i]);
        bitx(1'b0, a);
        xb(8'hff, 1'b0, d1);
        drv(1'b0, 1'b1);
        drv(1'b1, 1'b1);
        drv(1'b1, 1'b0);
    endtask : rd2
endmodule : peiu_host

/* File: test/tb_pse_event_interrupt_unit.sv */
// self-checking bench of the power-sourcing event and alert unit
`define CHK(g, e) begin \
    n_checks++; \
    if ((g) !== (e)) begin \
        num_errors++; \
        $display("ERROR t=%0t got %h exp %h", $time, g, e); \
    end \
end
module tb_pse_event_interrupt_unit;
    timeunit 1ns;
    timeprecision 100ps;
    import peiu_pkg::*;
    typedef struct {int src; logic [3:0] v; logic [7:0] a, e, s;} peiu_row_t;
    // source, port bits, view address, view value, summary value
    peiu_row_t rows [8] = '{
        '{0, 4'h9, 8'h02, 8'h90, 8'h02}, '{1, 4'h6, 8'h02, 8'h06, 8'h01},
        '{2, 4'h3, 8'h04, 8'h03, 8'h08}, '{3, 4'hc, 8'h04, 8'hc0, 8'h10},
        '{4, 4'h5, 8'h06, 8'h50, 8'h04}, '{5, 4'ha, 8'h06, 8'h0a, 8'h20},
        '{6, 4'h1, 8'h08, 8'h10, 8'h20}, '{7, 4'h8, 8'h08, 8'h08, 8'h40}};
    int num_errors = 0;
    int n_checks = 0;
    logic clk_i, resetn_i, strap, sda, scl, pull, sda_oe, sda_out, alert_oe;
    logic [3:0] pok, sw, sup;
    logic [3:0] ev [6];
    logic [7:0] d0, d1;
    // open-drain data line with pull-up
    // the device only pulls when its enable is up and its data value is low
    assign sda = !((sda_oe && !sda_out) || pull);
    pse_event_interrupt_unit DUT (
        .clk_i(clk_i), .resetn_i(resetn_i), .scl_i(scl), .sda_in_i(sda), .sda_out_o(sda_out),
        .sda_oe_o(sda_oe), .addr_pins_i(4'h5), .standalone_strap_i(strap),
        .port_power_ok_i(pok), .port_switch_on_i(sw), .discovery_done_i(ev[0]),
        .class_done_i(ev[1]), .unplug_fault_i(ev[2]), .overload_timeout_i(ev[3]),
        .limit_timeout_i(ev[4]), .launch_fail_i(ev[5]), .thermal_trip_i(sup[3]),
        .bad_switch_i(sup[2]), .core_supply_low_i(sup[1]), .neg_supply_low_i(sup[0]),
        .alert_n_o(), .alert_oe_o(alert_oe));
    peiu_host HOST (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_pull_o(pull));
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = !clk_i;
    end
    task automatic end_of_test;
        $display("errors %0d checks %0d", num_errors, n_checks);
        if (num_errors == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_of_test
    task automatic rst(input logic s);
        strap = s;
        resetn_i = 1'b0;
        repeat (12) @(posedge clk_i);
        #2;
        resetn_i = 1'b1;
        repeat (4) @(posedge clk_i);
        #2;
    endtask : rst
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        HOST.rd(a, d);
        `CHK(d, e)
    endtask : rchk
    // port levels toggle and stay; the other sources get a one-cycle pulse
    task automatic pulse(input int s, input logic [3:0] v);
        if (s == 0) pok = pok ^ v;
        else if (s == 1) sw = sw ^ v;
        else if (s == 8) sup = v;
        else ev[s-2] = v;
        @(posedge clk_i);
        #2;
        ev = '{default: 4'h0};
        sup = 4'h0;
        repeat (3) @(posedge clk_i);
        #2;
    endtask : pulse
    initial begin
        #1500000;
        num_errors++;
        end_of_test();
    end
    initial begin
        pok = 4'h0;
        sw = 4'h0;
        sup = 4'h0;
        ev = '{default: 4'h0};
        rst(1'b1);
        rchk(8'h01, 8'he4);
        rchk(8'h00, 8'h00);
        foreach (rows[k]) begin
            pulse(rows[k].src, rows[k].v);
            `CHK(alert_oe, |(rows[k].s & 8'he4))
            rchk(rows[k].a, rows[k].e);
            rchk(8'h00, rows[k].s);
            rchk(rows[k].a + 8'h01, rows[k].e);
            rchk(rows[k].a, 8'h00);
        end
        pulse(0, 4'h9);
        rchk(8'h02, 8'h90);
        pulse(4, 4'h2);
        `CHK(alert_oe, 1'b1)
        HOST.wr(8'h17, 8'h00);
        `CHK(alert_oe, 1'b0)
        rchk(8'h17, 8'h00);
        HOST.wr(8'h17, 8'h80);
        `CHK(alert_oe, 1'b1)
        HOST.wr(8'h01, 8'h00);
        `CHK(alert_oe, 1'b0)
        rchk(8'h00, 8'h06);
        // second byte of one read comes from the clearing address
        HOST.rd2(8'h02, d0, d1);
        `CHK(d0, 8'h90)
        `CHK(d1, 8'h90)
        rchk(8'h00, 8'h04);
        // an event held through the clearing read must survive it
        ev[0] = 4'h1;
        rchk(8'h05, 8'h01);
        rchk(8'h04, 8'h01);
        ev[0] = 4'h0;
        HOST.wr(8'h1a, 8'h80);
        rchk(8'h00, 8'h00);
        rchk(8'h06, 8'h00);
        pulse(8, 4'h8);
        `CHK(alert_oe, 1'b1)
        rchk(8'h0a, 8'h80);
        pulse(8, 4'h3);
        rchk(8'h0b, 8'hb0);
        pulse(8, 4'h4);
        `CHK(alert_oe, 1'b0)
        rchk(8'h00, 8'h80);
        rchk(8'h30, 8'h00);
        rst(1'b0);
        rchk(8'h01, 8'h80);
        rchk(8'h02, 8'h00);
        `CHK(HOST.nacks, 0)
        end_of_test();
    end
endmodule : tb_pse_event_interrupt_unit
